// >>> core/mcb_map.svh
// address map, field positions and timing counts of the master clock board
`ifndef MCB_MAP_SVH
`define MCB_MAP_SVH
`define MCB_CMD_OFS       12'h000
`define MCB_STAT_OFS      12'h004
`define MCB_BW_OFS        12'h008
`define MCB_STEP_OFS      12'h00c
`define MCB_ROT_OFS       12'h010
`define MCB_CMD_SET_EN0   0
`define MCB_CMD_SET_EN1   1
`define MCB_CMD_CLR_EN0   2
`define MCB_CMD_CLR_EN1   3
`define MCB_CMD_NEXT_WORD 4
`define MCB_BW_W          3
`define MCB_BW_RESET      3'h0
`define MCB_CLK_MHZ       50
`define MCB_REF_MHZ       4
`define MCB_ACC_HALF      6'h19
`define MCB_INS_LO        6'h1f
`define MCB_INS_HI        6'h25
`define MCB_QT_HALF       2'h2
`define MCB_STROBE_NS     50
`define MCB_NW_NS         250
`define MCB_STROBE_CYC    (((`MCB_STROBE_NS * `MCB_CLK_MHZ) + 999) / 1000)
`define MCB_NW_CYC        (((`MCB_NW_NS * `MCB_CLK_MHZ) + 999) / 1000)
`endif

// >>> core/mcb_master_clock.sv
// master clock board: clock divider, strobes, 60 hz interrupt, pulsed delay
//
// How it works
// - all clocks derived from one oscillator
// - control and readout clocks 4 MHz square
// - two separate 1 MHz square waves
// - multiplier strobes 50 ns at 4 MHz
// - shift strobes 4 MHz down to 31.25 kHz
// - next word gives 250 ns pulse
// - 60 Hz tick sets request if enabled
// - sample clock sets interrupt, raises request line
// - acknowledge clears the request flip-flop
// - pending DMA holds interrupt flip-flop clear
// - DMA pending blocks ack clear of request
// - interrupt address lines left undriven
// - program sets and clears interrupt enables
// - jump strobe clears interrupt enables
// - reset button while halted clears enables
// - independent A-B and B-C delay control
// - lag deletes, lead inserts unload pulse
// - each step shifts unload by 250 ns
// - B-C rotator phase is C minus B
`include "mcb_map.svh"
`default_nettype none
module mcb_master_clock (
  // apb slave
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // generated clocks and strobes
  output logic                      control_clock_4m,
  output logic      [1:0]           readout_shift_clock,
  output logic                      tc_quarter_clock,
  output logic                      delay_display_clock_1m,
  output logic                      multiplier_strobe,
  output logic      [1:0]           correlator_multiplier_strobes,
  output logic      [1:0]           correlator_shift_strobes,
  output logic                      next_word_pulse,
  // cpu i/o bus interrupt
  input  wire logic                 tick_60hz,
  input  wire logic                 intr_sample_clock,
  input  wire logic                 intr_acknowledge_line,
  input  wire logic                 intr_jump_strobe,
  input  wire logic                 dma_in_pending_n,
  input  wire logic                 dma_out_pending_n,
  input  wire logic                 system_reset_button,
  input  wire logic                 cpu_halted,
  output logic                      intr_request_line,
  output logic      [5:0]           intr_addr_out,
  output logic      [5:0]           intr_addr_oe_n,
  // pulsed delay, index 0 = pair a-b, index 1 = pair b-c
  output logic      [1:0]           unload_clock,
  // fringe rotator b-c
  input  wire logic [7:0]           rotator_b_phase,
  input  wire logic [7:0]           rotator_c_phase,
  output logic      [7:0]           rotator_bc_phase
);
  import mcb_pkg::*;

  localparam int STROBE_CYC = `MCB_STROBE_CYC;
  localparam int NW_CYC     = `MCB_NW_CYC;

  // ==========================================================
  // reference divider
  logic [5:0] acc_reg;
  logic [5:0] acc_next;
  logic       ref_tick;
  logic [6:0] sum_w;

  // fractional divider: one wrap per 4 mhz period on average
  always_comb begin
    sum_w = {1'b0, acc_reg} + 7'(`MCB_REF_MHZ);
    ref_tick = (sum_w >= 7'(`MCB_CLK_MHZ));
    acc_next = ref_tick ? 6'(sum_w - 7'(`MCB_CLK_MHZ)) : sum_w[5:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 6'h00;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ==========================================================
  // square wave outputs
  logic [1:0] qt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_clock_4m <= 1'b0;
    end else begin
      control_clock_4m <= (acc_next < `MCB_ACC_HALF);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_half
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          readout_shift_clock[gi] <= 1'b0;
        end else begin
          readout_shift_clock[gi] <= (acc_next < `MCB_ACC_HALF);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qt_reg                 <= 2'h0;
      tc_quarter_clock       <= 1'b0;
      delay_display_clock_1m <= 1'b0;
    end else begin
      if (ref_tick) begin
        qt_reg                 <= qt_reg + 2'h1;
        tc_quarter_clock       <= (qt_reg + 2'h1) < `MCB_QT_HALF;
        delay_display_clock_1m <= (qt_reg + 2'h1) < `MCB_QT_HALF;
      end
    end
  end

  // ==========================================================
  // strobes
  logic [`MCB_BW_W-1:0] bw_reg;
  logic [6:0]           bw_div_reg;
  logic [6:0]           bw_mask;
  logic                 shift_tick;
  logic [1:0]           mult_cnt_reg;
  logic [1:0]           shift_cnt_reg;

  assign bw_mask    = 7'((8'h01 << bw_reg) - 8'h01);
  assign shift_tick = ref_tick && ((bw_div_reg & bw_mask) == 7'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_div_reg <= 7'h00;
    end else if (ref_tick) begin
      bw_div_reg <= bw_div_reg + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_cnt_reg <= 2'h0;
    end else if (ref_tick) begin
      mult_cnt_reg <= 2'(STROBE_CYC);
    end else if (mult_cnt_reg != 2'h0) begin
      mult_cnt_reg <= mult_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_cnt_reg <= 2'h0;
    end else if (shift_tick) begin
      shift_cnt_reg <= 2'(STROBE_CYC);
    end else if (shift_cnt_reg != 2'h0) begin
      shift_cnt_reg <= shift_cnt_reg - 2'h1;
    end
  end

  assign multiplier_strobe = (mult_cnt_reg != 2'h0);
  generate
    for (gi = 0; gi < 2; gi++) begin : g_strobe
      assign correlator_multiplier_strobes[gi] = (mult_cnt_reg != 2'h0);
      assign correlator_shift_strobes[gi]      = (shift_cnt_reg != 2'h0);
    end
  endgenerate

  // ==========================================================
  // next word shaper
  mcb_nw_type nw_state_reg;
  logic [3:0] nw_cnt_reg;
  logic       nw_cmd;

  // pulse starts with the multiplier strobe for a fixed phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nw_state_reg <= MCB_NW_IDLE;
      nw_cnt_reg   <= 4'h0;
    end else begin
      case (nw_state_reg)
        MCB_NW_IDLE: begin
          if (nw_cmd) begin
            nw_state_reg <= MCB_NW_ARMED;
          end
        end
        MCB_NW_ARMED: begin
          if (ref_tick) begin
            nw_state_reg <= MCB_NW_PULSE;
            nw_cnt_reg   <= 4'(NW_CYC - 1);
          end
        end
        MCB_NW_PULSE: begin
          if (nw_cnt_reg == 4'h0) begin
            nw_state_reg <= MCB_NW_IDLE;
          end else begin
            nw_cnt_reg <= nw_cnt_reg - 4'h1;
          end
        end
        default: nw_state_reg <= MCB_NW_IDLE;
      endcase
    end
  end

  assign next_word_pulse = (nw_state_reg == MCB_NW_PULSE);

  // ==========================================================
  // 60 hz interrupt
  logic [1:0] en_reg;
  logic       req_reg;
  logic       intr_reg;
  logic       dma_pending;
  logic [1:0] en_set;
  logic [1:0] en_clr;

  assign dma_pending = !dma_in_pending_n || !dma_out_pending_n;

  // set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 2'h0;
    end else if (intr_jump_strobe || (system_reset_button && cpu_halted)) begin
      en_reg <= 2'h0;
    end else begin
      en_reg <= en_set | (en_reg & ~en_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 1'b0;
    end else if (tick_60hz && (en_reg == 2'h3)) begin
      req_reg <= 1'b1;
    end else if (intr_acknowledge_line && !dma_pending) begin
      req_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intr_reg <= 1'b0;
    end else if (dma_pending) begin
      intr_reg <= 1'b0;
    end else if (intr_sample_clock) begin
      intr_reg <= req_reg;
    end
  end

  assign intr_request_line = intr_reg;
  assign intr_addr_out     = 6'h00;
  assign intr_addr_oe_n    = 6'h3f;

  // ==========================================================
  // pulsed delay, one unload divider per recorder pair
  mcb_step_type [1:0] step_cmd;
  mcb_step_type [1:0] step_pend_reg;
  logic         [1:0] step_busy_reg;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_delay
      logic ins_reg;
      logic del_reg;
      logic del_now;
      // requests wait for the next unload period boundary
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_pend_reg[gi] <= '0;
          ins_reg           <= 1'b0;
          del_reg           <= 1'b0;
        end else if (ref_tick) begin
          ins_reg           <= step_pend_reg[gi].lead;
          del_reg           <= step_pend_reg[gi].lag;
          step_pend_reg[gi] <= step_cmd[gi];
        end else begin
          step_pend_reg[gi] <= step_pend_reg[gi] | step_cmd[gi];
        end
      end
      assign step_busy_reg[gi] = ins_reg || del_reg;
      // a delete must also mask the first high cycle, which starts at the wrap
      assign del_now = ref_tick ? step_pend_reg[gi].lag : del_reg;
      // delete masks one high phase, insert adds one in the low phase
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          unload_clock[gi] <= 1'b0;
        end else if (acc_next < `MCB_ACC_HALF) begin
          unload_clock[gi] <= !del_now;
        end else begin
          unload_clock[gi] <= ins_reg && (acc_next >= `MCB_INS_LO) &&
                              (acc_next < `MCB_INS_HI);
        end
      end
    end
  endgenerate

  // ==========================================================
  // fringe rotator b-c
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rotator_bc_phase <= 8'h00;
    end else begin
      rotator_bc_phase <= rotator_c_phase - rotator_b_phase;
    end
  end

  // ==========================================================
  // apb register file
  logic apb_wr;
  logic hit;

  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign hit     = (paddr == `MCB_CMD_OFS) || (paddr == `MCB_STAT_OFS) ||
                   (paddr == `MCB_BW_OFS) || (paddr == `MCB_STEP_OFS) ||
                   (paddr == `MCB_ROT_OFS);
  assign pslverr = psel && penable && !hit;

  always_comb begin
    en_set   = 2'h0;
    en_clr   = 2'h0;
    nw_cmd   = 1'b0;
    step_cmd = '0;
    if (apb_wr && (paddr == `MCB_CMD_OFS)) begin
      en_set[0] = pwdata[`MCB_CMD_SET_EN0];
      en_set[1] = pwdata[`MCB_CMD_SET_EN1];
      en_clr[0] = pwdata[`MCB_CMD_CLR_EN0];
      en_clr[1] = pwdata[`MCB_CMD_CLR_EN1];
      nw_cmd    = pwdata[`MCB_CMD_NEXT_WORD];
    end
    if (apb_wr && (paddr == `MCB_STEP_OFS)) begin
      step_cmd = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_reg <= `MCB_BW_RESET;
    end else if (apb_wr && (paddr == `MCB_BW_OFS)) begin
      bw_reg <= pwdata[`MCB_BW_W-1:0];
    end
  end

  // read data is latched in the setup phase and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `MCB_STAT_OFS: prdata <= {27'h0, nw_state_reg != MCB_NW_IDLE, intr_reg,
                                  req_reg, en_reg};
        `MCB_BW_OFS:   prdata <= {29'h0, bw_reg};
        `MCB_STEP_OFS: prdata <= {26'h0, step_busy_reg, step_pend_reg};
        `MCB_ROT_OFS:  prdata <= {24'h0, rotator_bc_phase};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // assertions
  logic [3:0] nw_w_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nw_w_reg <= 4'h0;
    end else begin
      nw_w_reg <= next_word_pulse ? nw_w_reg + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_strobe_body(sig);
    sig [*3] ##1 !sig;
  endsequence

  AST_MULT_WIDTH: assert property (
      $rose(multiplier_strobe) |-> s_strobe_body(multiplier_strobe))
    else $error("multiplier strobe width wrong");
  AST_SHIFT_WIDTH: assert property (
      $rose(correlator_shift_strobes[0]) |-> s_strobe_body(correlator_shift_strobes[0]))
    else $error("shift strobe width wrong");
  AST_NW_WIDTH: assert property ($fell(next_word_pulse) |-> nw_w_reg == 4'(NW_CYC))
    else $error("next word pulse width wrong");
  AST_REQ_SET: assert property (tick_60hz && en_reg == 2'h3 |=> req_reg)
    else $error("request not set by tick");
  AST_DMA_BLOCK: assert property (dma_pending |=> !intr_request_line)
    else $error("interrupt raised during dma");
  AST_REQ_HOLD: assert property (req_reg && dma_pending |=> req_reg)
    else $error("request lost during dma");
  AST_ACK_CLR: assert property (
      req_reg && intr_acknowledge_line && !dma_pending && !tick_60hz |=> !req_reg)
    else $error("ack did not clear request");
  AST_JUMP: assert property (intr_jump_strobe |=> en_reg == 2'h0)
    else $error("jump strobe left enable set");
  AST_HALT_RST: assert property (system_reset_button && cpu_halted |=> en_reg == 2'h0)
    else $error("reset while halted left enable set");
  AST_ADDR_OFF: assert property (intr_addr_oe_n == 6'h3f)
    else $error("interrupt address driven");
  AST_STEP_DONE: assert property (
      $rose(step_pend_reg[0].lag) |-> ##[1:14] g_delay[0].del_reg)
    else $error("lag step not applied");
  AST_BC_PHASE: assert property ($past(presetn) |->
      rotator_bc_phase == 8'($past(rotator_c_phase) - $past(rotator_b_phase)))
    else $error("b-c phase wrong");

endmodule // mcb_master_clock
`default_nettype wire

// >>> core/mcb_pkg.sv
// types shared by the master clock board
`default_nettype none
package mcb_pkg;
  typedef struct packed {
    logic lead;
    logic lag;
  } mcb_step_type;
  typedef enum logic [1:0] {
    MCB_NW_IDLE,
    MCB_NW_ARMED,
    MCB_NW_PULSE
  } mcb_nw_type;
endpackage
`default_nettype wire

// >>> tb/mcb_cpu_model.sv
// host cpu i/o bus model: sample clock, acknowledge, jump and dma pending
`default_nettype none
module mcb_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench control
  input  wire logic dma_busy,
  // i/o bus
  input  wire logic intr_request_line,
  output logic      intr_sample_clock,
  output logic      intr_acknowledge_line,
  output logic      intr_jump_strobe,
  output logic      dma_in_pending_n,
  output logic      dma_out_pending_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_reg;
  logic       seen_reg;
  // ==========================================
  // bus timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg               <= 4'h0;
      seen_reg              <= 1'b0;
      intr_sample_clock     <= 1'b0;
      intr_acknowledge_line <= 1'b0;
      intr_jump_strobe      <= 1'b0;
      dma_in_pending_n      <= 1'b1;
      dma_out_pending_n     <= 1'b1;
    end else begin
      div_reg           <= div_reg + 4'h1;
      seen_reg          <= intr_request_line;
      intr_sample_clock <= (div_reg == 4'hf);
      // interrupt accepted, or a dma transfer acknowledged on the shared line
      intr_acknowledge_line <= (intr_request_line && !seen_reg) ||
                               (dma_busy && div_reg[2:0] == 3'h3);
      intr_jump_strobe      <= intr_request_line && !seen_reg;
      // a busy bus alternates input and output transfers every eight cycles
      dma_in_pending_n      <= !(dma_busy && !div_reg[3]);
      dma_out_pending_n     <= !(dma_busy && div_reg[3]);
    end
  end
endmodule // mcb_cpu_model
`default_nettype wire

// >>> tb/test_correlator_master_clock_board.sv
// self-checking bench of the master clock board
`include "mcb_map.svh"
`default_nettype none
module test_correlator_master_clock_board;
  timeunit 1ns;
  timeprecision 1ns;
  import mcb_pkg::*;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d;} mcb_row_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        control_clock_4m, tc_quarter_clock, delay_display_clock_1m, multiplier_strobe;
  logic [1:0]  readout_shift_clock, correlator_multiplier_strobes, correlator_shift_strobes;
  logic        next_word_pulse, tick_60hz, intr_sample_clock, intr_acknowledge_line;
  logic        intr_jump_strobe, dma_in_pending_n, dma_out_pending_n, system_reset_button;
  logic        cpu_halted, intr_request_line, dma_busy;
  logic [5:0]  intr_addr_out, intr_addr_oe_n;
  logic [1:0]  unload_clock, pu;
  logic [7:0]  rotator_b_phase, rotator_c_phase, rotator_bc_phase;
  logic [9:0]  mon, pm;
  int          n_errors, samples_checked, cnt[10], run5, last5, run8, last8, dd0, dd1;
  int          a0, a1, b0, b1, w, k;
  logic [31:0] rd;
  logic        er;
  mcb_row_type rows[16];
  int          expc[10] = '{640, 640, 640, 160, 160, 640, 640, 640, 5, 5};
  assign mon = {correlator_shift_strobes, correlator_multiplier_strobes, multiplier_strobe,
                delay_display_clock_1m, tc_quarter_clock, readout_shift_clock, control_clock_4m};
  mcb_master_clock dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .control_clock_4m, .readout_shift_clock, .tc_quarter_clock,
    .delay_display_clock_1m, .multiplier_strobe, .correlator_multiplier_strobes,
    .correlator_shift_strobes, .next_word_pulse, .tick_60hz, .intr_sample_clock,
    .intr_acknowledge_line, .intr_jump_strobe, .dma_in_pending_n, .dma_out_pending_n,
    .system_reset_button, .cpu_halted, .intr_request_line, .intr_addr_out, .intr_addr_oe_n,
    .unload_clock, .rotator_b_phase, .rotator_c_phase, .rotator_bc_phase);
  mcb_cpu_model cpu_u (.pclk, .presetn, .dma_busy, .intr_request_line, .intr_sample_clock,
    .intr_acknowledge_line, .intr_jump_strobe, .dma_in_pending_n, .dma_out_pending_n);
  // ==========================================
  // clock and monitors
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    pm <= mon;
    pu <= unload_clock;
    for (int i = 0; i < 10; i++) cnt[i] += int'(mon[i] && !pm[i]);
    dd0 += int'(unload_clock[0] && !pu[0]) - int'(mon[0] && !pm[0]);
    dd1 += int'(unload_clock[1] && !pu[1]) - int'(mon[0] && !pm[0]);
    if (mon[5]) run5++; else begin if (run5 != 0) last5 = run5; run5 = 0; end
    if (mon[8]) run8++; else begin if (run8 != 0) last8 = run8; run8 = 0; end
  end
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic tick();
    @(posedge pclk) tick_60hz <= 1'b1;
    @(posedge pclk) tick_60hz <= 1'b0;
  endtask
  task automatic wait_line(input logic v, input int n);
    for (int i = 0; i < n && intr_request_line !== v; i++) @(posedge pclk);
    chk("intr_request_line", v, intr_request_line);
  endtask
  task automatic snap(output int s0, output int s1);
    @(posedge control_clock_4m);
    repeat (6) @(negedge pclk);
    s0 = dd0;
    s1 = dd1;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_errors++;
    tally_and_finish();
  end
  // ==========================================
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, tick_60hz, dma_busy} = '0;
    {system_reset_button, cpu_halted, pm, pu, dd0, dd1, run5, run8, last5, last8} = '0;
    rotator_b_phase = 8'h30;
    rotator_c_phase = 8'h10;
    rows = '{'{1, `MCB_BW_OFS, 7}, '{0, `MCB_BW_OFS, 7}, '{1, `MCB_BW_OFS, 32'hffff_fffa},
      '{0, `MCB_BW_OFS, 2}, '{0, `MCB_ROT_OFS, 32'he0}, '{1, `MCB_CMD_OFS, 1},
      '{0, `MCB_STAT_OFS, 1}, '{1, `MCB_CMD_OFS, 2}, '{0, `MCB_STAT_OFS, 3},
      '{1, `MCB_CMD_OFS, 4}, '{0, `MCB_STAT_OFS, 2}, '{1, `MCB_CMD_OFS, 13},
      '{0, `MCB_STAT_OFS, 1}, '{1, `MCB_CMD_OFS, 4}, '{0, `MCB_CMD_OFS, 0}, '{1, `MCB_BW_OFS, 7}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("stat_reset", `MCB_STAT_OFS, 32'h0);
    rdc("bw_reset", `MCB_BW_OFS, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      else rdc("reg_row", rows[i].a, rows[i].d);
    end
    apb(1'b1, 12'h020, 32'h1);
    chk("pslverr", 1'b1, er);
    @(negedge pclk) cnt = '{default: 0};
    repeat (8000) @(posedge pclk);
    @(negedge pclk);
    for (int i = 0; i < 10; i++) begin
      w = (cnt[i] >= expc[i] - 1 && cnt[i] <= expc[i] + 1) ? expc[i] : cnt[i];
      chk("edge_count", expc[i], w);
    end
    chk("cm_width", `MCB_STROBE_CYC, last5);
    chk("cs_width", `MCB_STROBE_CYC, last8);
    apb(1'b1, `MCB_CMD_OFS, 32'h10);
    for (w = 0; w < 100 && next_word_pulse !== 1'b1; w++) @(posedge pclk);
    chk("nw_start", 1'b1, next_word_pulse);
    chk("nw_align", 1'b1, multiplier_strobe);
    chk("nw_align_rise", 1'b0, pm[5]);
    for (w = 0; w < 100 && next_word_pulse === 1'b1; w++) @(posedge pclk);
    chk("nw_width", `MCB_NW_CYC, w);
    // steps spaced well apart so the recorders could follow
    for (k = 0; k < 4; k++) begin
      snap(a0, a1);
      apb(1'b1, `MCB_STEP_OFS, 32'h1 << k);
      repeat (40) @(posedge pclk);
      snap(b0, b1);
      chk("unload_ab", (k < 2) ? (k[0] ? 1 : -1) : 0, b0 - a0);
      chk("unload_bc", (k > 1) ? (k[0] ? 1 : -1) : 0, b1 - a1);
    end
    chk("addr_oe_n", 6'h3f, intr_addr_oe_n);
    chk("addr_out", 6'h0, intr_addr_out);
    apb(1'b1, `MCB_CMD_OFS, 32'h3);
    tick();
    wait_line(1'b1, 40);
    wait_line(1'b0, 60);
    rdc("stat_after_jump", `MCB_STAT_OFS, 32'h0);
    tick();
    repeat (40) @(posedge pclk);
    chk("no_req_disabled", 1'b0, intr_request_line);
    apb(1'b1, `MCB_CMD_OFS, 32'h3);
    dma_busy <= 1'b1;
    tick();
    repeat (60) @(posedge pclk);
    chk("dma_hold", 1'b0, intr_request_line);
    rdc("stat_dma", `MCB_STAT_OFS, 32'h7);
    dma_busy <= 1'b0;
    wait_line(1'b1, 40);
    wait_line(1'b0, 60);
    apb(1'b1, `MCB_CMD_OFS, 32'h3);
    system_reset_button <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("stat_running", `MCB_STAT_OFS, 32'h3);
    cpu_halted <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc("stat_halted", `MCB_STAT_OFS, 32'h0);
    {system_reset_button, cpu_halted} <= 2'b00;
    apb(1'b1, `MCB_CMD_OFS, 32'h3);
    apb(1'b1, `MCB_BW_OFS, 32'h5);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("stat_rereset", `MCB_STAT_OFS, 32'h0);
    rdc("bw_rereset", `MCB_BW_OFS, 32'h0);
    tally_and_finish();
  end
endmodule // test_correlator_master_clock_board
`default_nettype wire
